// file: hw/iac_top.sv
// acknowledge-cycle chip-select comparator with internal autovector
// assumes bus inputs synchronous to clk and an ahb-lite register master
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module iac_top
  import iac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic irq_pending, // interrupt recognised, internal or external source
  input wire logic [2:0] irq_level, // level of that interrupt
  input wire logic irq_internal, // source is an internal module
  input wire logic instr_done, // current instruction finished
  input wire logic arb_won, // arbitration cycle identified source
  input wire logic data_size_acknowledge_in, // external responder ack
  input wire logic bus_error_termination, // bus error on the cycle
  input wire logic [7:0] ext_vector, // vector from outside responder
  output logic [2:0] function_code_lines,
  output logic [23:0] addr_out,
  output logic address_strobe,
  output logic [NLINES-1:0] cs_pin_n,
  output logic autovector_request,
  output logic fast_termination,
  output logic [7:0] vector_out,
  output logic vector_valid,
  output logic spurious
);
  // =====================================================
  // reset release
  // the rest of the block leaves reset on a clock edge, never mid-cycle
  logic rs1_r, rst_sync_n; // two-flop release
  // both flops clear at once and set over two edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_sync_n <= rs1_r;
    end
  end

  // =====================================================
  // registers
  logic [15:0] base_r [NLINES]; // chip_select_base_address
  logic [15:0] opt_r [NLINES]; // chip_select_options
  logic [7:0] pin_r; // chip_select_pin_assignment
  logic [4:0] cfg_r; // [3:0] arbitration priority, [4] 32-bit variant
  logic [3:0] stat_r; // autovector_request, ext ack, spurious, matched
  // last outcome, kept until the next acknowledge ends

  // ahb address phase capture
  logic wr_pend_r;
  logic [7:0] wa_r;
  logic [31:0] rd_nxt;
  // a transfer is taken when selected, ready and nonsequential or sequential
  wire logic take = hsel && hready && htrans[1];

  // =====================================================
  // bus slave: zero wait states, always okay
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
      hrdata <= 32'h0;
      // ready and okay never change after reset
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // a write finishes one cycle later, when hwdata stands
      wr_pend_r <= take && hwrite;
      if (take) begin
        wa_r <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata <= rd_nxt; // read data ready in the data phase
      end
    end
  end

  // read decode
  // unmapped offsets and the unused line slots read as zero
  always_comb begin
    rd_nxt = 32'h0;
    if (haddr[7:0] == OFF_PIN) begin
      rd_nxt = {24'h0, pin_r};
    end else if (haddr[7:0] == OFF_CFG) begin
      rd_nxt = {27'h0, cfg_r};
    end else if (haddr[7:0] == OFF_STAT) begin
      rd_nxt = {28'h0, stat_r};
    end else if (haddr[7:0] < 8'(8 * NLINES) && haddr[1:0] == 2'h0) begin
      if (haddr[2]) begin
        rd_nxt = {16'h0, opt_r[haddr[LW+2:3]]};
      end else begin
        rd_nxt = {16'h0, base_r[haddr[LW+2:3]]};
      end
    end
  end

  // register writes
  // writes land at the end of the data phase
  // status is read only, so a write to it falls through
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < NLINES; i++) begin
        base_r[i] <= BASE_RST;
        opt_r[i] <= OPT_RST;
      end
      pin_r <= PIN_RST;
      cfg_r <= CFG_RST;
    end else if (wr_pend_r) begin
      if (wa_r == OFF_PIN) begin
        pin_r <= hwdata[7:0];
      end else if (wa_r == OFF_CFG) begin
        cfg_r <= hwdata[4:0];
      end else if (wa_r < 8'(8 * NLINES) && wa_r[1:0] == 2'h0) begin
        if (wa_r[2]) begin
          opt_r[wa_r[LW+2:3]] <= hwdata[15:0];
        end else begin
          base_r[wa_r[LW+2:3]] <= hwdata[15:0];
        end
      end
    end
  end

  // =====================================================
  // comparator per line; byte and ack-mode fields not looked at
  // true when one line's comparator answers the current acknowledge
  function automatic logic line_match(input logic [15:0] b, input logic [15:0] o,
                                      input logic [2:0] lvl);
    logic amatch, rmatch, lmatch;
    amatch = 1'b0;
    rmatch = 1'b0;
    lmatch = 1'b0;
    // block of 2 Kbytes compares address 23..11 against base 15..3
    amatch = (b[BASE_ADDR_HI:BASE_ADDR_LO] == 13'h1fff) && (b[BLK_HI:BLK_LO] == 3'h0);
    rmatch = (o[OPT_RW_HI:OPT_RW_LO] == RW_READ) || (o[OPT_RW_HI:OPT_RW_LO] == RW_BOTH);
    lmatch = (o[OPT_IPL_HI:OPT_IPL_LO] == 3'h0) || (o[OPT_IPL_HI:OPT_IPL_LO] == lvl);
    line_match = amatch && rmatch && lmatch && !o[OPT_MODE] && !o[OPT_STROBE_SELECT_FIELD]
                 && (o[OPT_SPACE_HI:OPT_SPACE_LO] == SPACE_CPU);
  endfunction : line_match

  // =====================================================
  // acknowledge sequence
  typedef enum logic [2:0] {S_IDLE, S_WAIT_INSTR, S_ARB, S_ACK, S_DONE} iac_state_t;
  iac_state_t st_r, st_nxt;
  // level held from recognition to the end of the acknowledge
  logic [2:0] lvl_r;
  // source kind held too: internal sources never autovector
  logic int_src_r;
  logic [NLINES-1:0] hit;
  logic [NLINES-1:0] autovector_request_hit;

  // which lines match this acknowledge
  // matching runs whatever the pin assignment; pins are gated later
  always_comb begin
    hit = '0;
    autovector_request_hit = '0;
    for (int i = 0; i < NLINES; i++) begin
      hit[i] = line_match(base_r[i], opt_r[i], lvl_r);
      autovector_request_hit[i] = hit[i] && opt_r[i][OPT_AUTOVECTOR_REQUEST];
    end
  end

  // next state
  // a waiting acknowledge ends on any of three answers
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (irq_pending) st_nxt = S_WAIT_INSTR;
      S_WAIT_INSTR: if (instr_done) st_nxt = S_ARB;
      S_ARB: if (arb_won) st_nxt = S_ACK;
      S_ACK: begin
        // internal autovector ends the cycle at once
        if ((!int_src_r && |autovector_request_hit) || data_size_acknowledge_in || bus_error_termination) begin
          st_nxt = S_DONE;
        end
      end
      S_DONE: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // state and the captured level and source
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_r <= S_IDLE;
      lvl_r <= 3'h0;
      int_src_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == S_IDLE && irq_pending) begin
        lvl_r <= irq_level;
        int_src_r <= irq_internal;
      end
    end
  end

  // =====================================================
  // bus drive during acknowledge
  // strobe, codes and address rise as the sequence enters ack
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      function_code_lines <= 3'h0;
      addr_out <= 24'h0;
      address_strobe <= 1'b0;
      cs_pin_n <= '1;
    end else begin
      if (st_nxt == S_ACK) begin
        function_code_lines <= FC_CPU;
        addr_out <= {ADDR_INTERRUPT_ACKNOWLEDGE_CYCLE_HI, 1'b0, lvl_r};
        address_strobe <= 1'b1;
      end else begin
        function_code_lines <= 3'h0;
        addr_out <= 24'h0;
        address_strobe <= 1'b0;
      end
      // pins follow the strobe, so an autovector that ends the cycle
      // at once still shows the chip select for its one cycle
      for (int i = 0; i < NLINES; i++) begin
        // only chip-select assignments reach the pin
        cs_pin_n[i] <= !(st_nxt == S_ACK && hit[i] && pin_r[2*i+1]);
      end
    end
  end

  // =====================================================
  // termination and vector
  // one pulse per acknowledge; vector_out keeps the last vector
  logic autovector_request_now;
  assign autovector_request_now = st_r == S_ACK && !int_src_r && |autovector_request_hit;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      autovector_request <= 1'b0;
      fast_termination <= 1'b0;
      vector_out <= 8'h00;
      vector_valid <= 1'b0;
      spurious <= 1'b0;
      stat_r <= 4'h0;
    end else begin
      autovector_request <= autovector_request_now;
      fast_termination <= autovector_request_now;
      vector_valid <= 1'b0;
      spurious <= 1'b0;
      // internal autovector wins over any outside answer
      if (autovector_request_now) begin
        vector_out <= (cfg_r[4] ? VEC_BASE32 : VEC_BASE16) + 8'(lvl_r);
        vector_valid <= 1'b1;
        stat_r <= {1'b1, 1'b0, 1'b0, 1'b1};
      end else if (st_r == S_ACK && data_size_acknowledge_in) begin
        vector_out <= ext_vector;
        vector_valid <= 1'b1;
        stat_r <= {1'b0, 1'b1, 1'b0, |hit};
        // bus error: spurious only with priority zero
      end else if (st_r == S_ACK && bus_error_termination) begin
        spurious <= cfg_r[3:0] == ARB_ZERO;
        stat_r <= {2'b00, cfg_r[3:0] == ARB_ZERO, |hit};
      end
    end
  end
endmodule : iac_top
`default_nettype wire

// file: inc/iac_pkg.sv
// constants for the acknowledge-cycle chip-select comparator block
// assumes a 24-bit address bus and 3 function code lines on the bus side
package iac_pkg;
  // =====================================================
  // register map (word aligned, ahb-lite)
  localparam logic [7:0] OFF_BASE0 = 8'h00; // base of line 0, line n at +8*n
  localparam logic [7:0] OFF_OPT0 = 8'h04; // options of line 0
  localparam logic [7:0] OFF_PIN = 8'h40; // pin assignment, two bits per line
  localparam logic [7:0] OFF_CFG = 8'h44; // arbitration priority and cpu variant
  localparam logic [7:0] OFF_STAT = 8'h48; // last acknowledge outcome
  localparam int NLINES = 4; // chip-select lines
  localparam int LW = 2; // line index width
  // =====================================================
  // base register fields
  localparam int BASE_ADDR_HI = 15;
  localparam int BASE_ADDR_LO = 3;
  localparam int BLK_HI = 2;
  localparam int BLK_LO = 0;
  localparam logic [15:0] BASE_RST = 16'h0000;
  // =====================================================
  // option register fields
  localparam int OPT_MODE = 15; // 0 asynchronous_mode
  localparam int OPT_BYTE_HI = 14;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_HI = 12; // 01 read, 11 read/write
  localparam int OPT_RW_LO = 11;
  localparam int OPT_STROBE_SELECT_FIELD = 10; // 0 address_strobe timing
  localparam int OPT_ACK_HI = 9;
  localparam int OPT_ACK_LO = 6;
  localparam int OPT_SPACE_HI = 5; // 00 cpu space
  localparam int OPT_SPACE_LO = 4;
  localparam int OPT_IPL_HI = 3;
  localparam int OPT_IPL_LO = 1;
  localparam int OPT_AUTOVECTOR_REQUEST = 0;
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_BOTH = 2'h3;
  localparam logic [1:0] SPACE_CPU = 2'h0;
  localparam logic [1:0] BYTE_OFF = 2'h0; // no byte selected; line_match ignores the byte field, so the line can still match
  // =====================================================
  // pin assignment codes
  localparam logic [1:0] PIN_ALT = 2'h0;
  localparam logic [1:0] PIN_GPO = 2'h1;
  localparam logic [1:0] PIN_CS8 = 2'h2;
  localparam logic [1:0] PIN_CS16 = 2'h3;
  localparam logic [7:0] PIN_RST = 8'h00;
  // =====================================================
  // acknowledge cycle encodings and vectors
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [19:0] ADDR_INTERRUPT_ACKNOWLEDGE_CYCLE_HI = 20'hfffff; // address bits 23..4
  localparam logic [7:0] VEC_BASE16 = 8'h0a; // level n gives 10+n
  localparam logic [7:0] VEC_BASE32 = 8'h18; // level n gives 24+n
  localparam logic [3:0] ARB_ZERO = 4'h0;
  localparam logic [4:0] CFG_RST = 5'h00;
endpackage : iac_pkg

// file: test/iac_asserts.sv
// checker on the comparator top ports
// assumes irq_internal is held for the whole acknowledge
`timescale 1ns/1ps
`default_nettype none
module iac_chk
  import iac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq_internal,
  input wire logic [2:0] function_code_lines,
  input wire logic [23:0] addr_out,
  input wire logic address_strobe,
  input wire logic [NLINES-1:0] cs_pin_n,
  input wire logic autovector_request,
  input wire logic fast_termination,
  input wire logic [7:0] vector_out,
  input wire logic vector_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================
  // acknowledge cycle outputs and register bus response
  fc_ones_a: assert property (address_strobe |-> function_code_lines == FC_CPU)
    else $error("function codes not all ones");
  addr_ones_a: assert property (address_strobe |-> addr_out[23:4] == ADDR_INTERRUPT_ACKNOWLEDGE_CYCLE_HI)
    else $error("high address not all ones");
  fast_end_a: assert property (autovector_request |-> fast_termination)
    else $error("autovector without fast end");
  auto_pulse_a: assert property (autovector_request |=> !autovector_request)
    else $error("autovector longer than a pulse");
  auto_vector_a: assert property (autovector_request |-> vector_valid &&
    (vector_out inside {[8'h0b:8'h11], [8'h19:8'h1f]}))
    else $error("autovector number out of range");
  auto_ext_a: assert property (autovector_request |-> !irq_internal)
    else $error("autovector for internal source");
  auto_cause_a: assert property (autovector_request |->
    address_strobe || $past(address_strobe))
    else $error("autovector outside acknowledge");
  pin_ack_a: assert property ((cs_pin_n != '1) |->
    address_strobe || $past(address_strobe))
    else $error("chip select outside acknowledge");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("register bus not ready or okay");
  // main scenarios reached
  auto_c: cover property (autovector_request);
  ext_c: cover property (vector_valid && !autovector_request);
  pin_c: cover property (cs_pin_n != '1);
endmodule : iac_chk
bind iac_top iac_chk u_chk (.clk, .rst_n, .hreadyout, .hresp, .irq_internal,
  .function_code_lines, .addr_out, .address_strobe, .cs_pin_n,
  .autovector_request, .fast_termination, .vector_out, .vector_valid);
`default_nettype wire

// file: test/iac_src.sv
// far side: interrupt source, sequencer and responder
// assumes bench commands on go, steady while busy
`timescale 1ns/1ps
`default_nettype none
module iac_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic intl,
  input wire logic [2:0] lvl,
  input wire logic [1:0] md,
  input wire logic [1:0] dly,
  input wire logic [7:0] vec,
  input wire logic address_strobe,
  output logic irq_pending,
  output logic [2:0] irq_level,
  output logic irq_internal,
  output logic instr_done,
  output logic arb_won,
  output logic data_size_acknowledge_in,
  output logic bus_error_termination,
  output logic [7:0] ext_vector
);
  logic busy_r, seen_r;
  logic [3:0] cnt_r;
  logic [1:0] md_r;
  // ==========================
  // request, wait, arbitrate, answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      seen_r <= 1'b0;
      cnt_r <= 4'h0;
      md_r <= 2'h0;
      irq_level <= 3'h0;
      irq_internal <= 1'b0;
      ext_vector <= 8'h00;
    end else if (go) begin
      busy_r <= 1'b1;
      seen_r <= 1'b0;
      cnt_r <= 4'h0;
      md_r <= md;
      irq_level <= lvl;
      irq_internal <= intl;
    end else begin
      if (busy_r && cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
      if (address_strobe) seen_r <= 1'b1;
      if (seen_r && !address_strobe) busy_r <= 1'b0;
      // own vector while answering, else a moving pattern
      ext_vector <= (address_strobe && md_r == 2'h1) ? vec : ~ext_vector;
    end
  end
  assign irq_pending = busy_r && !seen_r;
  assign instr_done = busy_r && cnt_r > {2'h0, dly};
  assign arb_won = instr_done && cnt_r > {2'h0, dly} + 4'h2;
  assign data_size_acknowledge_in = busy_r && seen_r && md_r == 2'h1;
  assign bus_error_termination = busy_r && seen_r && md_r == 2'h2;
endmodule : iac_src
`default_nettype wire

// file: test/iac_top_bench.sv
// bench: registers over ahb-lite, then acknowledge cycles
// assumes zero-wait slave and the far-side model iac_src
`timescale 1ns/1ps
`default_nettype none
module iac_top_bench;
  import iac_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, go = 0, intl = 0;
  logic [1:0] htrans = 0, md = 0, dly = 0;
  logic [2:0] hsize = 3'h2, lvl = 0, irq_level, function_code_lines;
  logic [31:0] haddr = 0, hwdata = 0, r = 32'hd587, q, hrdata;
  logic [7:0] vec = 0, ext_vector, vector_out, vq, pin = 0;
  logic hreadyout, hresp, irq_pending, irq_internal, instr_done, arb_won;
  logic data_size_acknowledge_in, bus_error_termination, address_strobe, spurious;
  logic autovector_request, fast_termination, vector_valid, av, vv, sp, seen;
  logic [23:0] addr_out;
  logic [3:0] cs_pin_n, csl;
  logic [2:0] al;
  logic [15:0] mb [4] = '{default: 0}, mo [4] = '{default: 0};
  logic [4:0] cfg = 0;
  int bad_count = 0, n_tests = 0, a, p, n, l;
  iac_top dut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq_pending, .irq_level,
    .irq_internal, .instr_done, .arb_won, .data_size_acknowledge_in,
    .bus_error_termination, .ext_vector, .function_code_lines, .addr_out,
    .address_strobe, .cs_pin_n, .autovector_request, .fast_termination,
    .vector_out, .vector_valid, .spurious);
  iac_src src (.clk, .rst_n, .go, .intl, .lvl, .md, .dly, .vec, .address_strobe,
    .irq_pending, .irq_level, .irq_internal, .instr_done, .arb_won,
    .data_size_acknowledge_in, .bus_error_termination, .ext_vector);
  initial begin
    forever #4 clk = ~clk;
  end
  // ==========================
  // helpers
  function logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task final_report;
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task rdy;
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (hreadyout !== 1'b1 && i < 20);
    if (i >= 20) begin bad_count++; final_report; end
  endtask : rdy
  task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask : xfer
  task wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
    if (ad < 8 * NLINES && ad[2]) mo[ad[4:3]] = d[15:0];
    if (ad < 8 * NLINES && !ad[2]) mb[ad[4:3]] = d[15:0];
    if (ad == OFF_PIN) pin = d[7:0];
    if (ad == OFF_CFG) cfg = d[4:0];
  endtask : wr
  function logic [31:0] mx(input logic [7:0] ad);
    if (ad < 8 * NLINES) return {16'h0, ad[2] ? mo[ad[4:3]] : mb[ad[4:3]]};
    return ad == OFF_PIN ? {24'h0, pin} : ad == OFF_CFG ? {27'h0, cfg} : 0;
  endfunction : mx
  function logic [15:0] opt(input logic [2:0] lv, input logic e, input logic [31:0] x);
    return {1'b0, x[1:0], x[2], 1'b1, 1'b0, x[6:3], SPACE_CPU, lv, e};
  endfunction : opt
  always @(posedge clk) begin
    av <= go ? 1'b0 : av | autovector_request;
    vv <= go ? 1'b0 : vv | vector_valid;
    sp <= go ? 1'b0 : sp | spurious;
    seen <= go ? 1'b0 : seen | address_strobe;
    csl <= go ? 4'h0 : csl | ~cs_pin_n;
    if (address_strobe) al <= addr_out[2:0];
    if (vector_valid) vq <= vector_out;
  end
  // one acknowledge against the register model
  task ack(input logic [2:0] lv, input logic i, input logic [1:0] m);
    logic [3:0] mt;
    logic au;
    int k;
    mt = 0;
    for (k = 0; k < 4; k++)
      mt[k] = mb[k][15:3] == 13'h1fff && mo[k][11] && mo[k][5:4] == 0 &&
        (mo[k][3:1] == 0 || mo[k][3:1] == lv);
    au = !i && |(mt & {mo[3][0], mo[2][0], mo[1][0], mo[0][0]});
    @(posedge clk);
    r = xs(r);
    {lvl, intl, md, dly, vec} <= {lv, i, m, r[1:0], r[15:8]};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin @(posedge clk); k++; end while (!(seen && !address_strobe) && k < 60);
    if (k >= 60) begin bad_count++; final_report; end
    repeat (3) @(posedge clk);
    chk("auto", av, au);
    chk("vvalid", vv, m == 1 || au);
    if (m == 1 || au) chk("vector", vq, au ? (cfg[4] ? 24 : 10) + lv : vec);
    chk("spurious", sp, m == 2 && !au && cfg[3:0] == 0);
    chk("pins", csl, mt & {pin[7], pin[5], pin[3], pin[1]});
    chk("level", al, lv);
    xfer(1'b0, OFF_STAT, 0);
    chk("status", q, {au, m == 1 && !au, m == 2 && !au && cfg[3:0] == 0, |mt});
  endtask : ack
  // ==========================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (a = 0; a <= 'h4c; a += 4) begin
      xfer(1'b0, a[7:0], 0);
      chk("reset", q, 0);
    end
    for (a = 0; a <= 'h4c; a += 4) begin
      r = xs(r);
      wr(a[7:0], r);
      xfer(1'b0, a[7:0], 0);
      chk("reg", q, mx(a[7:0]));
    end
    for (p = 0; p < 2; p++) begin
      for (n = 0; n < 4; n++) begin
        r = xs(r);
        wr(8 * n, 32'hfff8);
        wr(8 * n + 4, opt(n == 0 ? 3 * p : r[9:7], n == 0 || r[10], r));
      end
      for (l = 1; l < 8; l++) begin
        r = xs(r);
        wr(OFF_PIN, r);
        wr(OFF_CFG, {r[8], 4'h5});
        ack(l, 1'b0, 2'h1);
      end
    end
    ack(3'h3, 1'b1, 2'h1);
    wr(OFF_CFG, 0);
    ack(3'h2, 1'b1, 2'h2);
    wr(OFF_CFG, 1);
    ack(3'h2, 1'b1, 2'h2);
    final_report;
  end
endmodule : iac_top_bench
`default_nettype wire
